//--- logic/adc_sysref_cfg.sv
// Device and reference configuration register bank behind the serial port
`timescale 1ns/1ns
`default_nettype none
module adc_sysref_cfg #(
  parameter logic [15:0] MAKER_CODE = 16'h5a5a,  // Value arbitrary
  parameter int          TAP_DEPTH  = 32
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Serial register port
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sdi,
  output logic             spi_sdo,
  output logic             spi_sdo_oe,
  // Reference input and windowing status
  input  wire logic        sync_ref_in,
  input  wire logic [23:0] sync_capture_position,
  // Device controls
  output logic             device_power_down,
  output logic             sync_receiver_enable,
  output logic             sync_processor_enable,
  output logic             fine_delay_steps,
  output logic [3:0]       sync_delay_select,
  output logic             sync_polarity_invert,
  output logic             sample_clock_pecl_mode,
  output logic             sync_input_pecl_mode,
  output logic             sample_clock_self_bias,
  output logic             sync_input_self_bias,
  // Aligned reference
  output logic             sync_captured,
  output logic             sync_event
);

  localparam int TAP_W = $clog2(TAP_DEPTH);

  // The coarse step reaches tap 30, so the line needs 31 taps or more
  if (TAP_DEPTH < 32) begin : g_bad_taps
    $error("TAP_DEPTH must be at least 32");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  //////////////////////////////////////////////////////////////////////////
  // Address stepping for streaming transfers
  function automatic logic [14:0] next_addr(input logic [14:0] a,
                                            input logic        hold,
                                            input logic        up);
    if (hold) begin
      next_addr = a;
    end else if (up) begin
      next_addr = a + 15'h0001;
    end else begin
      next_addr = a - 15'h0001;
    end
  endfunction : next_addr

  //////////////////////////////////////////////////////////////////////////
  // Serial port
  serial_byte_if bus ();

  serial_byte_port u_port (
    .clk     (clk),
    .reset_n (reset_n),
    .sclk    (spi_sclk),
    .cs_n    (spi_cs_n),
    .sdi     (spi_sdi),
    .sdo     (spi_sdo),
    .sdo_oe  (spi_sdo_oe),
    .bus     (bus.port)
  );

  //////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0]  config_a;
  logic [7:0]  device_operating_config;
  logic [7:0]  serial_access_options;
  logic [7:0]  sync_reference_control;
  logic [7:0]  clock_input_options;
  logic [14:0] addr;
  logic        rd_mode;
  logic        rd_pend;
  logic        rd_load_q;
  logic [7:0]  rd_data;

  // Write strobes; only whole bytes of a write frame are taken
  wire wr_take   = bus.byte_valid & ~rd_mode;
  wire we_config = wr_take && (addr == cfg_pkg::A_CONFIG);
  wire we_device = wr_take && (addr == cfg_pkg::A_DEVICE);
  wire we_serial = wr_take && (addr == cfg_pkg::A_SERIAL);
  wire we_sync   = wr_take && (addr == cfg_pkg::A_SYNC_CTRL);
  wire we_clk    = wr_take && (addr == cfg_pkg::A_CLK_OPTS);

  // Streaming controls
  wire addr_hold = serial_access_options[cfg_pkg::BIT_HOLD];
  wire ascend    = config_a[cfg_pkg::BIT_ASCEND];

  // Writable registers; reserved bits keep what the host writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      config_a                <= cfg_pkg::RST_CONFIG;
      device_operating_config <= cfg_pkg::RST_DEVICE;
      serial_access_options   <= cfg_pkg::RST_SERIAL;
      sync_reference_control  <= cfg_pkg::RST_SYNC_CTRL;
      clock_input_options     <= cfg_pkg::RST_CLK_OPTS;
    end else begin
      if (we_config) begin
        config_a <= (bus.wr_byte & cfg_pkg::CONFIG_WMASK)
                    | cfg_pkg::CONFIG_FIXED;
      end
      if (we_device) begin
        device_operating_config <= bus.wr_byte;
      end
      if (we_serial) begin
        serial_access_options <= bus.wr_byte;
      end
      if (we_sync) begin
        sync_reference_control <= bus.wr_byte;
      end
      if (we_clk) begin
        clock_input_options <= bus.wr_byte;
      end
    end
  end

  // Frame address: loaded by the header, stepped after each byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr    <= 15'h0000;
      rd_mode <= 1'b0;
    end else if (bus.hdr_valid) begin
      addr    <= bus.hdr[cfg_pkg::ADDR_W-1:0];
      rd_mode <= bus.hdr[cfg_pkg::HDR_RD_BIT];
    end else if (bus.byte_valid) begin
      addr    <= next_addr(addr, addr_hold, ascend);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read path; read-only words have no write strobe at all
  logic [7:0] read_value;
  always_comb begin
    if (addr == cfg_pkg::A_CONFIG) begin
      read_value = config_a;
    end else if (addr == cfg_pkg::A_DEVICE) begin
      read_value = device_operating_config;
    end else if (addr == cfg_pkg::A_MAKER_LO) begin
      read_value = MAKER_CODE[7:0];
    end else if (addr == cfg_pkg::A_MAKER_HI) begin
      read_value = MAKER_CODE[15:8];
    end else if (addr == cfg_pkg::A_SERIAL) begin
      read_value = serial_access_options;
    end else if (addr == cfg_pkg::A_SYNC_CTRL) begin
      read_value = sync_reference_control;
    end else if (addr == cfg_pkg::A_CLK_OPTS) begin
      read_value = clock_input_options;
    end else if (addr == cfg_pkg::A_POS_0) begin
      read_value = sync_capture_position[7:0];
    end else if (addr == cfg_pkg::A_POS_1) begin
      read_value = sync_capture_position[15:8];
    end else if (addr == cfg_pkg::A_POS_2) begin
      read_value = sync_capture_position[23:16];
    end else begin
      read_value = 8'h00;                             // Unmapped reads zero
    end
  end

  // Read byte follows the stepped address by one cycle, the byte pulse by two
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_pend   <= 1'b0;
      rd_load_q <= 1'b0;
      rd_data   <= 8'h00;
    end else begin
      rd_pend   <= bus.hdr_valid | bus.byte_valid;
      rd_load_q <= rd_pend;
      if (rd_pend) begin
        rd_data <= read_value;
      end
    end
  end

  assign bus.rd_load = rd_load_q;
  assign bus.rd_byte = rd_data;

  //////////////////////////////////////////////////////////////////////////
  // Control outputs decoded from the register fields
  assign device_power_down =
    (device_operating_config[1:0] == cfg_pkg::MODE_PD);
  assign sync_processor_enable =
    sync_reference_control[cfg_pkg::BIT_PROC_EN];
  assign sync_receiver_enable =
    sync_reference_control[cfg_pkg::BIT_RECV_EN];
  assign fine_delay_steps  = sync_reference_control[cfg_pkg::BIT_FINE];
  assign sync_delay_select = sync_reference_control[cfg_pkg::SEL_MSB:0];
  assign sync_polarity_invert =
    clock_input_options[cfg_pkg::BIT_INVERT];
  assign sample_clock_pecl_mode =
    clock_input_options[cfg_pkg::BIT_CLK_PECL];
  assign sync_input_pecl_mode =
    clock_input_options[cfg_pkg::BIT_SYNC_PECL];
  // Self-bias must be off whenever the input is PECL-terminated
  assign sample_clock_self_bias = ~sample_clock_pecl_mode;
  assign sync_input_self_bias   = ~sync_input_pecl_mode;

  //////////////////////////////////////////////////////////////////////////
  // Reference capture; fine steps halve the tap spacing
  wire [TAP_W-1:0] tap_index = fine_delay_steps
    ? TAP_W'({1'b0, sync_delay_select})
    : TAP_W'({sync_delay_select, 1'b0});

  sync_tap_line #(
    .DEPTH (TAP_DEPTH)
  ) u_taps (
    .clk       (clk),
    .reset_n   (reset_n),
    .ref_pin   (sync_ref_in),
    .invert    (sync_polarity_invert),
    .enable    (sync_receiver_enable),
    .tap_index (tap_index),
    .sampled   (sync_captured)
  );

  // Event on a captured rising edge; held off until the processor runs
  logic captured_d;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      captured_d <= 1'b0;
      sync_event <= 1'b0;
    end else begin
      captured_d <= sync_captured;
      sync_event <= sync_processor_enable & sync_captured
                    & ~captured_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  // Power-down code carried by a completed write byte
  sequence s_write_pd;
    we_device && bus.wr_byte[1:0] == cfg_pkg::MODE_PD;
  endsequence

  // Completed byte while the streaming address is frozen
  sequence s_byte_frozen;
    bus.byte_valid && !bus.hdr_valid && addr_hold;
  endsequence

  // Completed write byte aimed at the read-only maker word
  sequence s_write_ro;
    wr_take && (addr == cfg_pkg::A_MAKER_LO
                || addr == cfg_pkg::A_MAKER_HI);
  endsequence

  // Code three powers the device down from the next cycle
  a_power_down : assert property (
    s_write_pd |=> device_power_down)
    else $error("power-down code did not take effect");

  // Frozen address repeats one register for every byte
  a_addr_frozen : assert property (
    s_byte_frozen |=> $stable(addr))
    else $error("frozen address moved");

  // Free address climbs by one when ascending
  a_addr_up : assert property (
    bus.byte_valid && !addr_hold && ascend
    |=> addr == $past(addr) + 15'h0001)
    else $error("ascending step wrong");

  // Free address falls by one when descending
  a_addr_down : assert property (
    bus.byte_valid && !addr_hold && !ascend
    |=> addr == $past(addr) - 15'h0001)
    else $error("descending step wrong");

  // Reference controls and direction bit still hold reset values
  a_ctrl_reset : assert property (
    $rose(reset_n) |->
    sync_reference_control == cfg_pkg::RST_SYNC_CTRL && ascend)
    else $error("reset value wrong");

  // No event unless the processor was on and the edge is new
  a_event_gate : assert property (
    sync_event |->
    $past(sync_processor_enable) && $past(sync_captured, 2) == 1'b0)
    else $error("event without processor enable");

  // Coarse steps read every second tap of the line
  a_tap_step : assert property (
    sync_receiver_enable && !fine_delay_steps
    |=> sync_captured == $past(u_taps.chain[{sync_delay_select, 1'b0}]))
    else $error("coarse tap spacing wrong");

  // Fine steps read the tap named by the select field itself
  a_tap_fine : assert property (
    sync_receiver_enable && fine_delay_steps
    |=> sync_captured == $past(u_taps.chain[sync_delay_select]))
    else $error("fine tap spacing wrong");

  // Writes aimed at the maker word leave the device, reference and clock option registers alone
  a_ro_hold : assert property (
    s_write_ro |=> $stable(device_operating_config)
    && $stable(sync_reference_control) && $stable(clock_input_options))
    else $error("read-only write disturbed a register");

  // A completed write byte to the reference controls lands there on the next cycle
  a_write_lands : assert property (
    wr_take && addr == cfg_pkg::A_SYNC_CTRL
    |=> sync_reference_control == $past(bus.wr_byte))
    else $error("write byte did not land");

endmodule : adc_sysref_cfg
`default_nettype wire

//--- inc/cfg_pkg.sv
// Register map, field positions and reset values of the configuration bank
`default_nettype none
package cfg_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Serial frame layout
  localparam int          ADDR_W      = 15;
  localparam int          HDR_BITS    = 16;
  localparam int          HDR_RD_BIT  = 15;
  localparam logic [4:0]  HDR_LAST    = 5'h0f;
  localparam logic [4:0]  BYTE_LAST   = 5'h07;

  //////////////////////////////////////////////////////////////////////////
  // Byte addresses
  localparam logic [14:0] A_CONFIG    = 15'h0000;
  localparam logic [14:0] A_DEVICE    = 15'h0002;
  localparam logic [14:0] A_MAKER_LO  = 15'h000c;
  localparam logic [14:0] A_MAKER_HI  = 15'h000d;
  localparam logic [14:0] A_SERIAL    = 15'h0010;
  localparam logic [14:0] A_SYNC_CTRL = 15'h0029;
  localparam logic [14:0] A_CLK_OPTS  = 15'h002a;
  localparam logic [14:0] A_POS_0     = 15'h002c;
  localparam logic [14:0] A_POS_1     = 15'h002d;
  localparam logic [14:0] A_POS_2     = 15'h002e;

  //////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]  RST_CONFIG    = 8'h30;
  localparam logic [7:0]  RST_DEVICE    = 8'h00;
  localparam logic [7:0]  RST_SERIAL    = 8'h00;
  localparam logic [7:0]  RST_SYNC_CTRL = 8'h80;
  localparam logic [7:0]  RST_CLK_OPTS  = 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // Field positions and codes
  localparam logic [7:0]  CONFIG_WMASK  = 8'h6f;  // Self-clearing bit 7 drops
  localparam logic [7:0]  CONFIG_FIXED  = 8'h10;  // Bit 4 always reads one
  localparam int          BIT_ASCEND    = 5;
  localparam int          BIT_HOLD      = 0;
  localparam logic [1:0]  MODE_PD       = 2'h3;
  localparam int          BIT_PROC_EN   = 6;
  localparam int          BIT_RECV_EN   = 5;
  localparam int          BIT_FINE      = 4;
  localparam int          SEL_MSB       = 3;
  localparam int          BIT_CLK_PECL  = 2;
  localparam int          BIT_SYNC_PECL = 1;
  localparam int          BIT_INVERT    = 0;

endpackage : cfg_pkg
`default_nettype wire

//--- inc/serial_byte_if.sv
// Byte-level carrier between the serial pin port and the register core
`timescale 1ns/1ns
`default_nettype none
interface serial_byte_if;
  logic        hdr_valid;   // One-cycle pulse, header complete
  logic [15:0] hdr;         // Read flag and address
  logic        byte_valid;  // One-cycle pulse, data byte complete
  logic [7:0]  wr_byte;     // Byte shifted in from the host
  logic        rd_load;     // One-cycle pulse, load read byte
  logic [7:0]  rd_byte;     // Byte to shift out

  modport port (output hdr_valid, hdr, byte_valid, wr_byte,
                input  rd_load, rd_byte);
  modport core (input  hdr_valid, hdr, byte_valid, wr_byte,
                output rd_load, rd_byte);
endinterface : serial_byte_if
`default_nettype wire

//--- logic/serial_byte_port.sv
// Serial pin port: synchronisers, header and byte shifting, read shifter
`timescale 1ns/1ns
`default_nettype none
module serial_byte_port (
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     reset_n,
  // Serial pins
  input  wire logic     sclk,
  input  wire logic     cs_n,
  input  wire logic     sdi,
  output logic          sdo,
  output logic          sdo_oe,
  // Byte side
  serial_byte_if.port   bus
);

  //////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers; only stage 1 is read by logic
  logic [1:0]  sclk_s;
  logic [1:0]  cs_s;
  logic [1:0]  sdi_s;
  logic        sclk_d;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_s <= 2'h0;
      cs_s   <= 2'h3;
      sdi_s  <= 2'h0;
      sclk_d <= 1'b0;
    end else begin
      sclk_s <= {sclk_s[0], sclk};
      cs_s   <= {cs_s[0], cs_n};
      sdi_s  <= {sdi_s[0], sdi};
      sclk_d <= sclk_s[1];
    end
  end

  // Edge and frame decode
  wire frame = ~cs_s[1];
  wire rise  = frame & sclk_s[1] & ~sclk_d;
  wire fall  = frame & ~sclk_s[1] & sclk_d;

  //////////////////////////////////////////////////////////////////////////
  // Receive shifter; header first, then bytes
  logic [14:0] shift;
  logic [4:0]  cnt;
  logic        in_data;
  logic        rd;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift <= 15'h0000; cnt <= 5'h00; in_data <= 1'b0; rd <= 1'b0;
      bus.hdr_valid <= 1'b0; bus.byte_valid <= 1'b0;
      bus.hdr <= 16'h0000; bus.wr_byte <= 8'h00;
    end else begin
      bus.hdr_valid  <= 1'b0;
      bus.byte_valid <= 1'b0;
      if (!frame) begin
        cnt <= 5'h00; in_data <= 1'b0; rd <= 1'b0;
      end else if (rise) begin
        shift <= {shift[13:0], sdi_s[1]};
        cnt   <= cnt + 5'h01;
        if (!in_data && cnt == cfg_pkg::HDR_LAST) begin
          bus.hdr_valid <= 1'b1;
          bus.hdr       <= {shift, sdi_s[1]};
          rd            <= shift[cfg_pkg::HDR_RD_BIT - 1];
          in_data       <= 1'b1;
          cnt           <= 5'h00;
        end else if (in_data && cnt == cfg_pkg::BYTE_LAST) begin
          bus.byte_valid <= 1'b1;  // Partial last byte is dropped
          bus.wr_byte    <= {shift[6:0], sdi_s[1]};
          cnt            <= 5'h00;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmit shifter; bits leave on falling edges, MSB first
  logic [7:0] tx;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx <= 8'h00; sdo <= 1'b0; sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= frame & in_data & rd;
      if (!frame) begin
        sdo <= 1'b0;
      end else if (bus.rd_load) begin
        tx <= bus.rd_byte;
      end else if (fall && in_data) begin
        sdo <= tx[7];
        tx  <= {tx[6:0], 1'b0};
      end
    end
  end

endmodule : serial_byte_port
`default_nettype wire

//--- logic/sync_tap_line.sv
// Reference input synchroniser, polarity option and tapped delay line
`timescale 1ns/1ns
`default_nettype none
module sync_tap_line #(
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // Reference pin and controls
  input  wire logic                     ref_pin,
  input  wire logic                     invert,
  input  wire logic                     enable,
  input  wire logic [$clog2(DEPTH)-1:0] tap_index,
  // Captured level
  output logic                          sampled
);

  if (DEPTH < 2 || DEPTH != (1 << $clog2(DEPTH))) begin : g_bad_depth
    $error("DEPTH must be a power of two of at least 2");
  end

  //////////////////////////////////////////////////////////////////////////
  // Synchronise, invert before capture, then delay
  logic [1:0]       ref_s;
  logic [DEPTH-1:0] chain;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_s   <= 2'h0;
      chain   <= '0;
      sampled <= 1'b0;
    end else begin
      ref_s   <= {ref_s[0], ref_pin};
      chain   <= {chain[DEPTH-2:0], ref_s[1] ^ invert};
      sampled <= enable & chain[tap_index];
    end
  end

  // Captured level never rises while the receiver is off
  a_recv_gate : assert property (
    @(posedge clk) disable iff (!reset_n) !enable |=> !sampled)
    else $error("capture while receiver off");

endmodule : sync_tap_line
`default_nettype wire

//--- tb/spi_host_model.sv
// Host serial controller model that drives the register port pins
`timescale 1ns/1ns
`default_nettype none
module spi_host_model #(
  parameter int HALF = 5  // Clocks per sclk phase, above the 4 minimum
) (
  // Clock
  input  wire logic clk,
  // Serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  // Idle pins at time zero: frame deselected, sclk low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // Wait whole clocks, then the fixed drive skew
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // One bit: data set while sclk low, sdo taken at the rising edge
  task automatic bit_io(input logic b, output logic r);
    sdi = b;
    tick(HALF);
    sclk = 1'b1;
    r    = sdo;
    tick(HALF);
    sclk = 1'b0;
  endtask : bit_io

  // Whole frame: header, then n streamed bytes from addr
  task automatic frame(input logic rd, input logic [14:0] addr,
                       input int n, input logic [7:0] wd [4],
                       output logic [7:0] rdd [4]);
    logic [15:0] hdr;
    logic        r;
    hdr  = {rd, addr};
    cs_n = 1'b0;
    tick(HALF);
    for (int i = 15; i >= 0; i--) bit_io(hdr[i], r);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) bit_io(wd[k][i], rdd[k][i]);
    end
    tick(HALF);
    cs_n = 1'b1;
    sdi  = ~sdi;  // Released line must not look like held data
    tick(8);      // Gap above 4 clocks, and the write has landed
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

//--- tb/adc_sysref_cfg_tb.sv
// Self-checking bench for the device and reference configuration bank
`timescale 1ns/1ns
`default_nettype none
module adc_sysref_cfg_tb;
  localparam logic [15:0] CODE  = 16'h3c96;     // Value arbitrary
  localparam logic [23:0] POS   = 24'h12_3456;
  localparam int          LIMIT = 60000;        // Run needs far fewer

  logic       clk, reset_n, sclk, cs_n, sdi, sdo, oe, ref_in;
  logic       pd, recv, proc, fine, inv, ck_pecl, rf_pecl, ck_bias;
  logic       rf_bias, capt, evt;
  logic [3:0] sel;
  int         num_errors = 0;
  int         comparisons = 0;
  int         cycles = 0;
  int         evt_count = 0;
  int         oe_count = 0;
  logic [7:0] wbuf [4];
  logic [7:0] rbuf [4];
  // Output groups laid out like the register bytes they decode
  wire logic [7:0] sync_view = {pd, proc, recv, fine, sel};
  wire logic [7:0] opt_view  = {3'h0, ck_bias, rf_bias, ck_pecl,
                                rf_pecl, inv};

  adc_sysref_cfg #(.MAKER_CODE(CODE)) dut_u (
    .clk(clk), .reset_n(reset_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(oe), .sync_ref_in(ref_in),
    .sync_capture_position(POS), .device_power_down(pd),
    .sync_receiver_enable(recv), .sync_processor_enable(proc),
    .fine_delay_steps(fine), .sync_delay_select(sel),
    .sync_polarity_invert(inv), .sample_clock_pecl_mode(ck_pecl),
    .sync_input_pecl_mode(rf_pecl), .sample_clock_self_bias(ck_bias),
    .sync_input_self_bias(rf_bias), .sync_captured(capt),
    .sync_event(evt));
  spi_host_model host_u (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
                         .sdo(sdo));

  //////////////////////////////////////////////////////////////////////////
  // Clock, event counter and hang guard
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (evt === 1'b1) evt_count++;
    if (oe === 1'b1) oe_count++;
    if (cycles == LIMIT) begin
      num_errors++;
      complete_run();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [14:0] a, input int n);
    host_u.frame(1'b0, a, n, wbuf, rbuf);
  endtask : wr
  task automatic put(input logic [14:0] a, input logic [7:0] v);
    wbuf[0] = v;
    wr(a, 1);
  endtask : put
  task automatic peek(input logic [14:0] a, input logic [7:0] exp);
    host_u.frame(1'b1, a, 1, wbuf, rbuf);
    check(rbuf[0], exp);
  endtask : peek
  // Raise the reference, count clocks until it is captured
  task automatic measure(output int n);
    ref_in = 1'b1;
    n = 0;
    while (capt !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    ref_in = 1'b0;
    repeat (40) @(posedge clk);
    #1;
  endtask : measure

  //////////////////////////////////////////////////////////////////////////
  // Scenarios; every write keeps reserved bits at their reset values
  task automatic t_reset;
    check(sync_view, 8'h00);
    check(opt_view, 8'h18);
    peek(cfg_pkg::A_CONFIG, 8'h30);
    peek(cfg_pkg::A_DEVICE, 8'h00);
    peek(cfg_pkg::A_SERIAL, 8'h00);
    peek(cfg_pkg::A_SYNC_CTRL, 8'h80);
    peek(cfg_pkg::A_CLK_OPTS, 8'h00);
  endtask : t_reset
  task automatic t_mode;
    for (int i = 0; i < 4; i++) begin
      put(cfg_pkg::A_DEVICE, 8'(i));
      check({7'h0, pd}, {7'h0, i == 3});
    end
    put(cfg_pkg::A_DEVICE, 8'h00);
  endtask : t_mode
  task automatic t_sync;
    put(cfg_pkg::A_SYNC_CTRL, 8'ha0);      // Receiver first
    check(sync_view, 8'h20);
    put(cfg_pkg::A_SYNC_CTRL, 8'he0);
    check(sync_view, 8'h60);
    put(cfg_pkg::A_SYNC_CTRL, 8'hfa);
    check(sync_view, 8'h7a);
  endtask : t_sync
  // Tap differences hide the fixed pipeline latency
  task automatic t_capture;
    int d0, d1, d2;
    put(cfg_pkg::A_SYNC_CTRL, 8'he0);
    measure(d0);
    check(8'(evt_count), 8'h01);
    put(cfg_pkg::A_SYNC_CTRL, 8'ha3);
    measure(d1);
    check(8'(d1 - d0), 8'h06);
    check(8'(evt_count), 8'h01);
    put(cfg_pkg::A_SYNC_CTRL, 8'hb3);
    measure(d2);
    check(8'(d2 - d0), 8'h03);
    put(cfg_pkg::A_SYNC_CTRL, 8'h80);
    measure(d1);
    check(8'(d1), 8'h28);
    put(cfg_pkg::A_SYNC_CTRL, 8'ha0);
  endtask : t_capture
  task automatic t_opts;
    logic [7:0] v;
    for (int i = 0; i < 3; i++) begin
      v = 8'(1 << i);
      put(cfg_pkg::A_CLK_OPTS, v);
      check(opt_view, {3'h0, ~v[2], ~v[1], v[2:0]});
      check({7'h0, capt}, {7'h0, v[0]});
    end
    put(cfg_pkg::A_CLK_OPTS, 8'h00);
  endtask : t_opts
  // Output enable stays low in writes, rises in reads, drops after
  task automatic t_readonly;
    int o;
    o = oe_count;
    put(cfg_pkg::A_MAKER_LO, 8'h00);
    put(cfg_pkg::A_POS_0, 8'hff);
    check(8'(oe_count - o), 8'h00);
    host_u.frame(1'b1, cfg_pkg::A_MAKER_LO, 2, wbuf, rbuf);
    check(rbuf[0], CODE[7:0]);
    check(rbuf[1], CODE[15:8]);
    check({7'h0, oe_count > o}, 8'h01);
    check({7'h0, oe}, 8'h00);
    host_u.frame(1'b1, cfg_pkg::A_POS_0, 3, wbuf, rbuf);
    for (int k = 0; k < 3; k++) check(rbuf[k], POS[8*k +: 8]);
  endtask : t_readonly
  task automatic t_stream;
    wbuf[0] = 8'h83;
    wbuf[1] = 8'h04;
    wr(cfg_pkg::A_SYNC_CTRL, 2);
    peek(cfg_pkg::A_CLK_OPTS, 8'h04);
    put(cfg_pkg::A_CONFIG, 8'h00);
    wbuf[0] = 8'h01;
    wbuf[1] = 8'h85;
    wr(cfg_pkg::A_CLK_OPTS, 2);
    peek(cfg_pkg::A_SYNC_CTRL, 8'h85);
    put(cfg_pkg::A_CONFIG, 8'h20);
    put(cfg_pkg::A_SERIAL, 8'h01);
    wbuf[0] = 8'h81;
    wbuf[1] = 8'h82;
    wr(cfg_pkg::A_SYNC_CTRL, 2);
    peek(cfg_pkg::A_SYNC_CTRL, 8'h82);
    peek(cfg_pkg::A_CLK_OPTS, 8'h01);
    put(cfg_pkg::A_SERIAL, 8'h00);
  endtask : t_stream

  //////////////////////////////////////////////////////////////////////////
  // Verdict and main sequence
  task automatic complete_run;
    $display("Compares %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  initial begin
    reset_n = 1'b0;
    ref_in  = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    t_reset();
    t_mode();
    t_sync();
    t_capture();
    t_opts();
    t_readonly();
    t_stream();
    complete_run();
  end
endmodule : adc_sysref_cfg_tb
`default_nettype wire
